// *** core/link_edge_detect.sv ***
`timescale 1ns/100ps
`default_nettype none
module link_edge_detect (
    // Clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       rst_n_in,
    // Pin levels and internal timing
    input  wire logic       ext_bclk_in,
    input  wire logic       ext_fsync_in,
    input  wire logic       int_bclk_in,
    input  wire logic       int_fsync_in,
    // Selection and polarity
    input  wire logic       use_int_bclk_in,
    input  wire logic       use_int_fsync_in,
    input  wire logic       bclk_invert_in,
    input  wire logic       fsync_invert_in,
    input  wire logic       launch_invert_in,
    // Timing events
    link_event_if.src       evt
);
    typedef struct packed {
        logic b1, b2, f1, f2, bprev, fprev;
        logic launch, half, sample, start_l, start_r;
    } edge_state_t;

    edge_state_t s, n;

    always_comb begin
        logic bn;
        logic fn;
        bn = 1'b0;
        fn = 1'b0;
        n = s;
        n.b1 = ext_bclk_in;
        n.b2 = s.b1;
        n.f1 = ext_fsync_in;
        n.f2 = s.f1;
        // [RQ13] [RQ5] Clock source and polarity
        bn = (use_int_bclk_in ? int_bclk_in : s.b2) ^ bclk_invert_in;
        // [RQ12] [RQ4] Sync source and polarity
        fn = (use_int_fsync_in ? int_fsync_in : s.f2) ^ fsync_invert_in;
        n.bprev = bn;
        n.sample = bn & ~s.bprev;
        // [RQ8] Launch on falling or following rising edge
        n.launch = launch_invert_in ? (bn & ~s.bprev) : (~bn & s.bprev);
        n.half = launch_invert_in ? (~bn & s.bprev) : (bn & ~s.bprev);
        n.start_l = 1'b0;
        n.start_r = 1'b0;
        if (bn & ~s.bprev) begin
            n.start_l = fn & ~s.fprev;
            n.start_r = ~fn & s.fprev;
            n.fprev = fn;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign evt.launch = s.launch;
    assign evt.half = s.half;
    assign evt.sample = s.sample;
    assign evt.start_left = s.start_l;
    assign evt.start_right = s.start_r;
endmodule
`default_nettype wire

// *** core/link_event_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface link_event_if;
    logic launch;
    logic half;
    logic sample;
    logic start_left;
    logic start_right;
    modport src (output launch, output half, output sample, output start_left,
                 output start_right);
    modport dst (input launch, input half, input sample, input start_left,
                 input start_right);
endinterface
`default_nettype wire

// *** core/secondary_serial_port_pkg.sv ***
// Notes on behaviour
// [RQ1] Page selector holds any value 0..255
// [RQ2] Format field: TDM, I2S, left-justified; 3 reserved
// [RQ3] Slot length 16/20/24/32, resets to 32
// [RQ4] Frame sync polarity bit inverts sync sense
// [RQ5] Bit clock polarity bit inverts clock sense
// [RQ6] Error detection active while its bit is 0
// [RQ7] Auto resume after error unless bit set
// [RQ8] Launch edge bit delays output half cycle
// [RQ9] Unused cycles drive zero or high impedance
// [RQ10] Last bit full cycle or half then released
// [RQ11] Keeper off, on, LSB one or 1.5 cycles
// [RQ12] Controller mode may use internal frame sync
// [RQ13] Controller mode may use internal bit clock
// [RQ14] TDM sync pulse one or two bit periods
// [RQ15] First slot MSB delayed 0..31 bit cycles
// [RQ16] Per-channel bit routes to second output pin
// [RQ17] Reset restores every configuration field value
package secondary_serial_port_pkg;
    // Register map
    localparam logic [7:0] ADDR_PAGE_SEL  = 8'h00;
    localparam logic [7:0] ADDR_PORT_CFG  = 8'h1a;
    localparam logic [7:0] ADDR_TX_CFG    = 8'h1b;
    localparam logic [7:0] ADDR_TX_OFS    = 8'h1c;
    localparam logic [7:0] ADDR_TX_ROUTE  = 8'h1d;
    localparam logic [7:0] ADDR_CTRL      = 8'h30;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h31;
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'h32;
    localparam logic [7:0] ADDR_STATE     = 8'h33;
    localparam logic [7:0] PAGE_MAIN      = 8'h00;
    // Reset values
    localparam logic [7:0] RST_PAGE       = 8'h00;
    localparam logic [7:0] RST_PORT_CFG   = 8'h30;
    localparam logic [7:0] RST_TX_CFG     = 8'h00;
    localparam logic [4:0] RST_TX_OFS     = 5'h00;
    localparam logic [7:0] RST_TX_ROUTE   = 8'h00;
    // Port configuration fields
    localparam int PC_FMT_LSB    = 6;
    localparam int PC_LEN_LSB    = 4;
    localparam int PC_FS_INV     = 3;
    localparam int PC_BCLK_INV   = 2;
    localparam int PC_ERR_OFF    = 1;
    localparam int PC_RESUME_OFF = 0;
    // Transmit configuration fields
    localparam int TC_EDGE       = 7;
    localparam int TC_FILL       = 6;
    localparam int TC_LSB_HALF   = 5;
    localparam int TC_KEEP_LSB   = 3;
    localparam int TC_INT_FS     = 2;
    localparam int TC_INT_BCLK   = 1;
    localparam int TC_PULSE2     = 0;
    localparam int OFS_W         = 5;
    // Encodings
    localparam logic [1:0] FMT_TDM     = 2'h0;
    localparam logic [1:0] FMT_I2S     = 2'h1;
    localparam logic [1:0] FMT_LJ      = 2'h2;
    localparam logic [1:0] FMT_RSVD    = 2'h3;
    localparam logic [1:0] KEEP_OFF    = 2'h0;
    localparam logic [1:0] KEEP_ALWAYS = 2'h1;
    localparam logic [1:0] KEEP_LSB1   = 2'h2;
    localparam logic [1:0] KEEP_LSB15  = 2'h3;
    localparam logic [2:0] LAST_SLOT   = 3'h7;
    // Interrupt events
    localparam int EV_BUS_ERR = 0;
    localparam int EV_RESUME  = 1;
    localparam int EV_FRAME   = 2;
    localparam int EV_W       = 3;
    // Timing
    localparam int CORE_PERIOD_NS     = 10;
    localparam int INT_BCLK_PERIOD_NS = 160;
    localparam int INT_BCLK_HALF_CYC  = INT_BCLK_PERIOD_NS / (2 * CORE_PERIOD_NS);
    localparam logic [3:0] DIV_LAST   = 4'(INT_BCLK_HALF_CYC - 1);
    localparam logic [8:0] FRAME_LIMIT = 9'h1ff;

    function automatic logic [5:0] slot_bits(input logic [1:0] sel);
        case (sel)
            2'h0:    return 6'h10;
            2'h1:    return 6'h14;
            2'h2:    return 6'h18;
            default: return 6'h20;
        endcase
    endfunction
endpackage

// *** core/secondary_serial_port_tx.sv ***
`timescale 1ns/100ps
`default_nettype none
module secondary_serial_port_tx
    import secondary_serial_port_pkg::*;
(
    // Clock and reset
    input  wire logic         core_clk_in,
    input  wire logic         rst_n_in,
    // Register port
    input  wire logic [7:0]   reg_addr_in,
    input  wire logic [7:0]   reg_wdata_in,
    input  wire logic         reg_wr_in,
    input  wire logic         reg_rd_in,
    output logic [7:0]        reg_rdata_out,
    // Serial link timing pins
    input  wire logic         bclk_in,
    input  wire logic         fsync_in,
    output logic              bclk_out,
    output logic              bclk_oe_out,
    output logic              fsync_out,
    output logic              fsync_oe_out,
    // Channel samples, channel k at bits 32k+31..32k
    input  wire logic [255:0] sample_data_in,
    // Serial data pins
    output logic              serial_out_primary_out,
    output logic              serial_out_primary_oe_out,
    output logic              serial_out_second_out,
    output logic              serial_out_second_oe_out,
    output logic              keeper_en_out,
    // Interrupt
    output logic              irq_out
);
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_ERR, ST_HALT} tx_state_t;

    typedef struct packed {
        tx_state_t        st;
        logic [7:0]       page;
        logic [7:0]       pcfg;
        logic [7:0]       tcfg;
        logic [4:0]       ofs;
        logic [7:0]       route;
        logic             ctrl_mode;
        logic [EV_W-1:0]  stat;
        logic [EV_W-1:0]  mask;
        logic [7:0]       rdata;
        logic             irq;
        logic [8:0]       bitpos;
        logic [4:0]       wait_cnt;
        logic [5:0]       bits_left;
        logic [2:0]       slot;
        logic [31:0]      shreg;
        logic             lsb_now;
        logic             pin_sel;
        logic [1:0]       keep_ph;
        logic             keep;
        logic             dp, dp_oe, ds, ds_oe;
        logic [3:0]       div;
        logic             ibclk;
        logic [8:0]       ibit;
        logic             bclk_o, bclk_oe, fs_o, fs_oe;
    } tx_reg_t;

    tx_reg_t s, n;

    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] clr;
    logic            load;
    logic            fsn;
    logic [1:0]      fmt;
    logic [1:0]      len_sel;
    logic [5:0]      len;
    logic [1:0]      keep_mode;
    logic [8:0]      frame_bits;
    logic            page0;
    logic            fs_inv_tot;
    logic            start_any;

    link_event_if evt ();

    function automatic logic [31:0] word_of(input logic [255:0] d, input logic [2:0] sl,
                                            input logic [5:0] wl);
        logic [31:0] w;
        w = d[{sl, 5'h00} +: 32];
        return w << (6'h20 - wl);
    endfunction

    assign fmt = s.pcfg[PC_FMT_LSB +: 2];
    assign len_sel = s.pcfg[PC_LEN_LSB +: 2];
    assign len = slot_bits(len_sel);
    assign keep_mode = s.tcfg[TC_KEEP_LSB +: 2];
    assign frame_bits = (fmt == FMT_TDM) ? {len, 3'h0} : {2'h0, len, 1'b0};
    assign page0 = (s.page == PAGE_MAIN);
    // I2S sync is low for the left slot, so its sense is flipped
    assign fs_inv_tot = s.pcfg[PC_FS_INV] ^ (fmt == FMT_I2S);
    assign start_any = evt.start_left | (evt.start_right & (fmt != FMT_TDM));

    link_edge_detect u_edge (
        .core_clk_in      (core_clk_in),
        .rst_n_in         (rst_n_in),
        .ext_bclk_in      (bclk_in),
        .ext_fsync_in     (fsync_in),
        .int_bclk_in      (s.bclk_o),
        .int_fsync_in     (s.fs_o),
        .use_int_bclk_in  (s.ctrl_mode & s.tcfg[TC_INT_BCLK]),
        .use_int_fsync_in (s.ctrl_mode & s.tcfg[TC_INT_FS]),
        .bclk_invert_in   (s.pcfg[PC_BCLK_INV]),
        .fsync_invert_in  (fs_inv_tot),
        .launch_invert_in (s.tcfg[TC_EDGE]),
        .evt              (evt)
    );

    always_comb begin
        n = s;
        ev = '0;
        clr = '0;
        load = 1'b0;
        fsn = 1'b0;
        // Register writes
        if (reg_wr_in) begin
            if (reg_addr_in == ADDR_PAGE_SEL) begin
                // [RQ1] Full 8-bit page value
                n.page = reg_wdata_in;
            end else if (page0) begin
                case (reg_addr_in)
                    ADDR_PORT_CFG: begin
                        n.pcfg = reg_wdata_in;
                        // [RQ7] Reconfiguration leaves power-down
                        if (s.st == ST_HALT) begin
                            n.st = ST_IDLE;
                        end
                    end
                    ADDR_TX_CFG:   n.tcfg = reg_wdata_in;
                    ADDR_TX_OFS:   n.ofs = reg_wdata_in[OFS_W-1:0];
                    ADDR_TX_ROUTE: n.route = reg_wdata_in;
                    ADDR_CTRL:     n.ctrl_mode = reg_wdata_in[0];
                    ADDR_IRQ_MASK: n.mask = reg_wdata_in[EV_W-1:0];
                    default: ;
                endcase
            end
        end
        // Register reads, data valid one cycle later only
        n.rdata = '0;
        if (reg_rd_in) begin
            if (reg_addr_in == ADDR_PAGE_SEL) begin
                n.rdata = s.page;
            end else if (page0) begin
                case (reg_addr_in)
                    ADDR_PORT_CFG: n.rdata = s.pcfg;
                    ADDR_TX_CFG:   n.rdata = s.tcfg;
                    ADDR_TX_OFS:   n.rdata = {3'h0, s.ofs};
                    ADDR_TX_ROUTE: n.rdata = s.route;
                    ADDR_CTRL:     n.rdata = {7'h00, s.ctrl_mode};
                    ADDR_IRQ_STAT: begin
                        n.rdata = {5'h00, s.stat};
                        clr = '1;
                    end
                    ADDR_IRQ_MASK: n.rdata = {5'h00, s.mask};
                    ADDR_STATE:    n.rdata = {6'h00, s.st};
                    default:       n.rdata = '0;
                endcase
            end
        end
        // Launch-edge data path
        if (evt.launch) begin
            // [RQ9] Unused cycles: zero or released
            n.dp = 1'b0;
            n.ds = 1'b0;
            n.dp_oe = ~s.tcfg[TC_FILL];
            n.ds_oe = ~s.tcfg[TC_FILL];
            n.lsb_now = 1'b0;
            if (s.keep_ph == 2'h1) begin
                n.keep_ph = (keep_mode == KEEP_LSB15) ? 2'h2 : 2'h0;
            end
            if (s.st == ST_RUN) begin
                if (s.wait_cnt != 5'h00) begin
                    n.wait_cnt = s.wait_cnt - 5'h01;
                end else if (s.bits_left != 6'h00) begin
                    // [RQ16] Channel routed to selected pin
                    n.pin_sel = s.route[s.slot];
                    if (s.route[s.slot]) begin
                        n.ds = s.shreg[31];
                        n.ds_oe = 1'b1;
                    end else begin
                        n.dp = s.shreg[31];
                        n.dp_oe = 1'b1;
                    end
                    n.shreg = s.shreg << 1;
                    n.bits_left = s.bits_left - 6'h01;
                    if (s.bits_left == 6'h01) begin
                        n.lsb_now = 1'b1;
                        // [RQ11] Keeper window opens at LSB
                        n.keep_ph = (keep_mode[1]) ? 2'h1 : 2'h0;
                        if (fmt == FMT_TDM && s.slot != LAST_SLOT) begin
                            n.slot = s.slot + 3'h1;
                            n.shreg = word_of(sample_data_in, s.slot + 3'h1, len);
                            n.bits_left = len;
                        end
                    end
                end
            end
        end
        if (evt.half) begin
            // [RQ10] Release pin for second half of LSB
            if (s.lsb_now && s.tcfg[TC_LSB_HALF]) begin
                if (s.pin_sel) begin
                    n.ds_oe = 1'b0;
                end else begin
                    n.dp_oe = 1'b0;
                end
            end
            if (s.keep_ph == 2'h2) begin
                n.keep_ph = 2'h0;
            end
        end
        // [RQ11] Keeper mode decode
        n.keep = (keep_mode == KEEP_ALWAYS) | ((keep_mode != KEEP_OFF) & (n.keep_ph != 2'h0));
        // Frame tracking and bus error handling
        case (s.st)
            ST_IDLE: begin
                if (start_any && fmt != FMT_RSVD) begin
                    n.st = ST_RUN;
                    load = 1'b1;
                end
            end
            ST_RUN: begin
                if (fmt == FMT_RSVD) begin
                    // [RQ2] Reserved format stops transmission
                    n.st = ST_IDLE;
                end else if (start_any) begin
                    load = 1'b1;
                end else if (s.bitpos == FRAME_LIMIT && !s.pcfg[PC_ERR_OFF]) begin
                    // [RQ6] Missing sync is a bus error
                    n.st = ST_ERR;
                    ev[EV_BUS_ERR] = 1'b1;
                end else if (evt.sample && s.bitpos != FRAME_LIMIT) begin
                    n.bitpos = s.bitpos + 9'h001;
                end
            end
            ST_ERR: begin
                // [RQ7] Resume or stay down on recovery
                if (evt.start_left && fmt != FMT_RSVD) begin
                    if (s.pcfg[PC_RESUME_OFF]) begin
                        n.st = ST_HALT;
                    end else begin
                        n.st = ST_RUN;
                        load = 1'b1;
                        ev[EV_RESUME] = 1'b1;
                    end
                end
            end
            ST_HALT: ;
            default: n.st = ST_IDLE;
        endcase
        if (load) begin
            n.bitpos = '0;
            n.slot = (evt.start_right & (fmt != FMT_TDM)) ? 3'h1 : 3'h0;
            // [RQ3] Word length from slot length field
            n.shreg = word_of(sample_data_in, n.slot, len);
            n.bits_left = len;
            // [RQ15] Delay of first MSB
            n.wait_cnt = s.ofs;
            ev[EV_FRAME] = evt.start_left;
        end
        // [RQ13] Internal bit clock divider
        if (s.ctrl_mode) begin
            if (s.div == DIV_LAST) begin
                n.div = '0;
                n.ibclk = ~s.ibclk;
                if (s.ibclk) begin
                    n.ibit = (s.ibit >= frame_bits - 9'h001) ? 9'h000 : s.ibit + 9'h001;
                end
            end else begin
                n.div = s.div + 4'h1;
            end
        end else begin
            n.div = '0;
            n.ibclk = 1'b0;
            n.ibit = '0;
        end
        // [RQ14] [RQ12] Internal sync: pulse in TDM, half frame otherwise
        if (fmt == FMT_TDM) begin
            fsn = n.ibit < (s.tcfg[TC_PULSE2] ? 9'h002 : 9'h001);
        end else begin
            fsn = n.ibit < {3'h0, len};
        end
        // [RQ4] [RQ5] Driven pins follow the polarity bits
        n.fs_o = fsn ^ fs_inv_tot;
        n.bclk_o = n.ibclk ^ s.pcfg[PC_BCLK_INV];
        n.bclk_oe = s.ctrl_mode;
        n.fs_oe = s.ctrl_mode;
        // New events win over a clearing read
        n.stat = (s.stat & ~clr) | ev;
        n.irq = |(n.stat & n.mask);
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            // [RQ17] Configuration reset values
            s <= '0;
            s.st <= ST_IDLE;
            s.page <= RST_PAGE;
            s.pcfg <= RST_PORT_CFG;
            s.tcfg <= RST_TX_CFG;
            s.ofs <= RST_TX_OFS;
            s.route <= RST_TX_ROUTE;
        end else begin
            s <= n;
        end
    end

    assign reg_rdata_out = s.rdata;
    assign bclk_out = s.bclk_o;
    assign bclk_oe_out = s.bclk_oe;
    assign fsync_out = s.fs_o;
    assign fsync_oe_out = s.fs_oe;
    assign serial_out_primary_out = s.dp;
    assign serial_out_primary_oe_out = s.dp_oe;
    assign serial_out_second_out = s.ds;
    assign serial_out_second_oe_out = s.ds_oe;
    assign keeper_en_out = s.keep;
    assign irq_out = s.irq;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence page_write_s;
        reg_wr_in && reg_addr_in == ADDR_PAGE_SEL;
    endsequence
    sequence page_read_s;
        reg_rd_in && reg_addr_in == ADDR_PAGE_SEL;
    endsequence
    sequence stable_cfg_s;
        $stable(s.pcfg) && $stable(s.tcfg) && s.ctrl_mode && $stable(s.ctrl_mode);
    endsequence

    // [RQ1] Page readback
    page_store_a: assert property ( // [RQ1]
        page_write_s ##1 !reg_wr_in ##1 page_read_s |=> reg_rdata_out == $past(reg_wdata_in, 3))
        else $error("page select readback wrong");
    // [RQ2] Reserved format
    reserved_fmt_a: assert property ( // [RQ2]
        s.st == ST_RUN && fmt == FMT_RSVD |=> s.st == ST_IDLE)
        else $error("reserved format kept running");
    // [RQ3] Slot length load
    slot_len_a: assert property ( // [RQ3]
        load |=> s.bits_left == slot_bits($past(len_sel)))
        else $error("slot length not loaded");
    // [RQ4] Sync sense at frame start
    sync_sense_a: assert property ( // [RQ4]
        stable_cfg_s and (fmt == FMT_TDM && s.ibit == 9'h000)
        |-> fsync_out == ~s.pcfg[PC_FS_INV])
        else $error("sync polarity wrong");
    // [RQ5] Bit clock sense
    bclk_sense_a: assert property ( // [RQ5]
        stable_cfg_s |-> bclk_out == (s.ibclk ^ s.pcfg[PC_BCLK_INV]))
        else $error("bit clock polarity wrong");
    // [RQ6] Error detection off
    err_off_a: assert property ( // [RQ6]
        s.st == ST_RUN && s.pcfg[PC_ERR_OFF] |=> s.st != ST_ERR)
        else $error("error raised while detection off");
    // [RQ7] Auto resume
    auto_resume_a: assert property ( // [RQ7]
        s.st == ST_ERR && evt.start_left && fmt != FMT_RSVD && !s.pcfg[PC_RESUME_OFF]
        |=> s.st == ST_RUN && s.stat[EV_RESUME])
        else $error("no resume after recovery");
    // [RQ9] Idle fill
    idle_fill_a: assert property ( // [RQ9]
        evt.launch && s.st != ST_RUN |=> !s.dp && s.dp_oe == !$past(s.tcfg[TC_FILL]))
        else $error("idle cycle drive wrong");
    // [RQ10] LSB half release
    lsb_half_a: assert property ( // [RQ10]
        evt.half && s.lsb_now && s.tcfg[TC_LSB_HALF] && !s.pin_sel |=> !s.dp_oe)
        else $error("LSB not released");
    // [RQ11] Keeper always on
    keep_on_a: assert property ( // [RQ11]
        keep_mode == KEEP_ALWAYS && !reg_wr_in |=> keeper_en_out)
        else $error("keeper not on");
    // [RQ14] Sync pulse width
    pulse_width_a: assert property ( // [RQ14]
        stable_cfg_s and (fmt == FMT_TDM && s.ibit == 9'h001)
        |-> (fsync_out ^ fs_inv_tot) == s.tcfg[TC_PULSE2])
        else $error("sync pulse width wrong");
    // [RQ15] First slot delay
    slot_delay_a: assert property ( // [RQ15]
        load |=> s.wait_cnt == $past(s.ofs))
        else $error("first slot delay wrong");
    // [RQ16] Second pin routing
    route_a: assert property ( // [RQ16]
        evt.launch && s.st == ST_RUN && s.wait_cnt == 5'h00 && s.bits_left != 6'h00
        && s.route[s.slot] |=> s.ds_oe && s.ds == $past(s.shreg[31]))
        else $error("channel not on second pin");
endmodule
`default_nettype wire

// *** testbench/audio_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module audio_host_model (
    // Control
    input  wire logic   sync_en_in,
    input  wire logic   data_in,
    // Link pins
    output logic        bclk_out,
    output logic        fsync_out,
    // Captured first word
    output logic [15:0] word_out,
    output logic        done_out
);
    int bit_n = 0;
    int cap_n = 16;
    initial begin
        bclk_out = 1'b0;
        fsync_out = 1'b0;
        word_out = 16'h0000;
    end
    always #80 bclk_out = ~bclk_out;
    always @(negedge bclk_out) begin
        bit_n <= (bit_n == 127) ? 0 : bit_n + 1;
        fsync_out <= sync_en_in && (bit_n == 127);
    end
    // Capture the first 16 bits after sync
    always @(posedge bclk_out) begin
        if (fsync_out) begin
            cap_n <= 0;
        end else if (cap_n < 16) begin
            word_out <= {word_out[14:0], data_in};
            cap_n <= cap_n + 1;
        end
    end
    assign done_out = (cap_n == 16);
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
    import secondary_serial_port_pkg::*;
    logic        core_clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        sync_en = 1'b1;
    logic [7:0]  rdata;
    logic        bclk, fsync, d1, oe1, irq, done, keep, bclk_oe;
    logic [15:0] word;
    int          n_fail = 0;
    int          total_checks = 0;
    int          cyc = 0;
    always #5 core_clk_in = ~core_clk_in;
    secondary_serial_port_tx i_secondary_serial_port_tx (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .bclk_in(bclk), .fsync_in(fsync), .bclk_out(), .bclk_oe_out(bclk_oe), .fsync_out(),
        .fsync_oe_out(), .sample_data_in({8{32'h1234a5c3}}),
        .serial_out_primary_out(d1), .serial_out_primary_oe_out(oe1),
        .serial_out_second_out(), .serial_out_second_oe_out(), .keeper_en_out(keep),
        .irq_out(irq));
    // Released pin shows the inverse of its last value
    audio_host_model i_audio_host_model (.sync_en_in(sync_en), .data_in(oe1 ? d1 : ~d1),
        .bclk_out(bclk), .fsync_out(fsync), .word_out(word), .done_out(done));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk_in);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] m,
                          input logic [7:0] exp);
        @(posedge core_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk_in);
        rd <= 1'b0;
        #1 chk(what, 16'(exp), 16'(rdata & m));
    endtask
    task automatic t_reset_values();
        rd_chk("page", ADDR_PAGE_SEL, 8'hff, 8'h00);
        rd_chk("port_cfg", ADDR_PORT_CFG, 8'hff, 8'h30);
        rd_chk("tx_cfg", ADDR_TX_CFG, 8'hff, 8'h00);
        rd_chk("tx_ofs", ADDR_TX_OFS, 8'hff, 8'h00);
    endtask
    task automatic t_regs();
        wr_reg(ADDR_PAGE_SEL, 8'hff);
        rd_chk("page", ADDR_PAGE_SEL, 8'hff, 8'hff);
        rd_chk("other_page", ADDR_PORT_CFG, 8'hff, 8'h00);
        wr_reg(ADDR_PAGE_SEL, 8'h00);
        wr_reg(ADDR_TX_OFS, 8'hff);
        rd_chk("tx_ofs", ADDR_TX_OFS, 8'hff, 8'h1f);
        rd_chk("unmapped", 8'h05, 8'hff, 8'h00);
        wr_reg(ADDR_TX_CFG, 8'ha5);
        rd_chk("tx_cfg", ADDR_TX_CFG, 8'hff, 8'ha5);
        wr_reg(ADDR_TX_CFG, 8'h00);
    endtask
    task automatic t_frame(input logic [7:0] ofs, input logic [15:0] exp);
        wr_reg(ADDR_TX_OFS, ofs);
        @(posedge done);
        @(posedge done);
        #1 chk("word", exp, word);
    endtask
    task automatic t_irq();
        chk("irq_on", 16'h1, 16'(irq));
        rd_chk("stat_frame", ADDR_IRQ_STAT, 8'h04, 8'h04);
        repeat (3) @(posedge core_clk_in);
        chk("irq_off", 16'h0, 16'(irq));
    endtask
    task automatic t_error();
        sync_en <= 1'b0;
        // Bus error after 511 bit clocks without frame start
        repeat (9000) @(posedge core_clk_in);
        rd_chk("stat_err", ADDR_IRQ_STAT, 8'h01, 8'h01);
        rd_chk("state_err", ADDR_STATE, 8'h03, 8'h02);
        sync_en <= 1'b1;
        @(posedge done);
        rd_chk("stat_resume", ADDR_IRQ_STAT, 8'h02, 8'h02);
        rd_chk("state_run", ADDR_STATE, 8'h03, 8'h01);
    endtask
    task automatic t_ctrl();
        // Slot 0 leaves the primary pin, which then floats high
        wr_reg(ADDR_PORT_CFG, 8'h02);
        wr_reg(ADDR_CTRL, 8'h01);
        wr_reg(ADDR_TX_CFG, 8'h69);
        wr_reg(ADDR_TX_ROUTE, 8'h01);
        t_frame(8'h00, 16'hffff);
        chk("keeper", 16'h1, 16'(keep));
        chk("bclk_oe", 16'h1, 16'(bclk_oe));
        rd_chk("state_noerr", ADDR_STATE, 8'h03, 8'h01);
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_fail++;
            wrap_up();
        end
    end
    initial begin
        repeat (5) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        t_reset_values();
        t_regs();
        // TDM, 16-bit slots
        wr_reg(ADDR_PORT_CFG, 8'h00);
        wr_reg(ADDR_IRQ_MASK, 8'h04);
        t_frame(8'h00, 16'ha5c3);
        t_irq();
        t_frame(8'h01, 16'h52e1);
        t_error();
        t_ctrl();
        wrap_up();
    end
endmodule
`default_nettype wire
